//--- rtl/pscr_power_seq.sv
// Power-state sequencer with clock-run and wake indication.
// Assumes config decode and link PHY are outside; inputs synchronous.
`timescale 1ns/1ps
module pscr_power_seq #(
  parameter int IDLE_CYC = pscr_pkg::IDLE_STANDBY_CYC
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire pscr_pkg::pscr_cfg_t cfg,
  input  wire pscr_pkg::pscr_evt_t evt,
  input  wire logic                pmeClear,
  input  wire logic                clkRunIn_n,
  output logic                     clkRunOut_n,
  output logic                     clkRunOe_n,
  output logic                     pmeOut_n,
  output logic                     pmeOe_n,
  output logic                     pmeStatus,
  output pscr_pkg::pscr_state_t    powerState,
  output logic                     busMasterAllow,
  output logic                     targetAllow,
  output logic                     irqAllow,
  output logic                     linkKeep,
  output logic                     deepPowerDown,
  output logic                     standby
);

  // ************************************************************
  // State register
  // ************************************************************
  pscr_pkg::pscr_state_t state_reg;
  pscr_pkg::pscr_state_t state_next;
  logic                  linkUp;
  logic                  linkDrop;
  logic                  wakeEvt;
  logic                  lowPower;
  logic [15:0]           idleCnt_reg;

  function automatic pscr_pkg::pscr_state_t decodeState(input logic [1:0] v);
    case (v)
      pscr_pkg::PSCR_PS_D1: decodeState = pscr_pkg::PSCR_D1;
      pscr_pkg::PSCR_PS_D2: decodeState = pscr_pkg::PSCR_D2;
      pscr_pkg::PSCR_PS_D3: decodeState = pscr_pkg::PSCR_D3;
      default:              decodeState = pscr_pkg::PSCR_D0A;
    endcase
  endfunction : decodeState

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pscr_pkg::PSCR_D0U: begin
        if (cfg.stateWrite && cfg.stateValue != pscr_pkg::PSCR_PS_D0) begin
          state_next = decodeState(cfg.stateValue);
        end else if (cfg.baseInit) begin
          state_next = pscr_pkg::PSCR_D0A;
        end
      end
      pscr_pkg::PSCR_D0A,
      pscr_pkg::PSCR_D1,
      pscr_pkg::PSCR_D2,
      pscr_pkg::PSCR_D3: begin
        if (cfg.stateWrite) begin
          state_next = decodeState(cfg.stateValue);
        end
      end
      default: state_next = pscr_pkg::PSCR_D0U;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= pscr_pkg::PSCR_D0U;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lowPower = (state_reg == pscr_pkg::PSCR_D1) || (state_reg == pscr_pkg::PSCR_D2) ||
                    (state_reg == pscr_pkg::PSCR_D3);

  // ************************************************************
  // Link monitor and wake events
  // ************************************************************
  pscr_linkmon u_linkmon (
    .clk       (clk),
    .nrst      (nrst),
    .linkValid (evt.linkValid),
    .linkUp    (linkUp),
    .linkDrop  (linkDrop)
  );

  always_comb begin
    wakeEvt = 1'b0;
    case (state_reg)
      pscr_pkg::PSCR_D0U: wakeEvt = linkUp || linkDrop;
      pscr_pkg::PSCR_D0A: wakeEvt = linkUp || linkDrop;
      pscr_pkg::PSCR_D1,
      pscr_pkg::PSCR_D2,
      pscr_pkg::PSCR_D3: begin
        // Packets only count while the link is valid
        wakeEvt = linkUp || linkDrop || (evt.wakePacket && evt.linkValid);
      end
      default: wakeEvt = 1'b0;
    endcase
    wakeEvt = wakeEvt && cfg.wakeEnable;
  end

  // Status survives until host clears it; a new event beats the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pmeStatus <= 1'b0;
    end else if (wakeEvt) begin
      pmeStatus <= 1'b1;
    end else if (pmeClear) begin
      pmeStatus <= 1'b0;
    end
  end

  // Wake pin is open drain; low enable pulls it low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pmeOut_n <= 1'b0;
      pmeOe_n  <= 1'b1;
    end else begin
      pmeOut_n <= 1'b0;
      pmeOe_n  <= !((pmeStatus || wakeEvt) && cfg.wakeEnable);
    end
  end

  // ************************************************************
  // Bus and link gating
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busMasterAllow <= 1'b0;
      targetAllow    <= 1'b1;
      irqAllow       <= 1'b0;
    end else begin
      busMasterAllow <= (state_next == pscr_pkg::PSCR_D0A);
      targetAllow    <= (state_next == pscr_pkg::PSCR_D0A) || (state_next == pscr_pkg::PSCR_D0U);
      irqAllow       <= (state_next == pscr_pkg::PSCR_D0A);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkKeep      <= 1'b1;
      deepPowerDown <= 1'b0;
    end else begin
      if (lowPower && !cfg.wakeEnable) begin
        linkKeep      <= 1'b0;
        deepPowerDown <= 1'b0;
      end else if ((state_reg == pscr_pkg::PSCR_D2 || state_reg == pscr_pkg::PSCR_D3) &&
                   !evt.linkValid && cfg.deepEnable) begin
        // Deep mode stops idle symbols, so two such nodes may never see each other
        linkKeep      <= 1'b0;
        deepPowerDown <= 1'b1;
      end else begin
        linkKeep      <= 1'b1;
        deepPowerDown <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Dynamic standby and clock demand
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idleCnt_reg <= 16'h0000;
      standby     <= 1'b0;
    end else if (state_reg != pscr_pkg::PSCR_D0A || evt.busyNeed) begin
      idleCnt_reg <= 16'h0000;
      standby     <= 1'b0;
    end else if (idleCnt_reg >= 16'(IDLE_CYC)) begin
      standby     <= 1'b1;
    end else begin
      idleCnt_reg <= idleCnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerState <= pscr_pkg::PSCR_D0U;
    end else begin
      powerState <= state_reg;
    end
  end

  // Clock is released only when idle; host restore latency is its own concern
  pscr_clkrun u_clkrun (
    .clk         (clk),
    .nrst        (nrst),
    .needClk     (evt.busyNeed || wakeEvt || pmeStatus),
    .enable      (cfg.clkRunEnable),
    .clkRunIn_n  (clkRunIn_n),
    .clkRunOut_n (clkRunOut_n),
    .clkRunOe_n  (clkRunOe_n)
  );

endmodule : pscr_power_seq

//--- rtl/pscr_pkg.sv
// Constants and carrier types for the power-state and clock-run block.
// Assumes a single 50 MHz clock and synchronous inputs.
// Function
// - Clock-run is a shared open-drain line
// - Device asserts line when needing clock
// - Disabled clock-run keeps clock claimed always
// - Dedicated wake event output to system
// - Four power states D0 to D3
// - Outside D0 only configuration accesses allowed
// - Reset enters uninitialized full power substate
// - Base register write moves to active
// - Active substate enters standby autonomously
// - D1 no bus mastering, no interrupts
// - D1 keeps link, asserts wake on event; code also drops link in D1 when wake disabled
// - D2 link down may enter deep mode
// - Deep mode enabled by driver control bit
// - D3 like D2; wake disabled drops link
// - Active wakes on any link status change
// - Low power wakes per link validity
// - Wake events only with enable bit set
package pscr_pkg;

  // ************************************************************
  // Power state encoding as written by the host
  // ************************************************************
  localparam logic [1:0] PSCR_PS_D0 = 2'h0;
  localparam logic [1:0] PSCR_PS_D1 = 2'h1;
  localparam logic [1:0] PSCR_PS_D2 = 2'h2;
  localparam logic [1:0] PSCR_PS_D3 = 2'h3;

  typedef enum logic [2:0] {
    PSCR_D0U,
    PSCR_D0A,
    PSCR_D1,
    PSCR_D2,
    PSCR_D3
  } pscr_state_t;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ           = 50;
  localparam int IDLE_STANDBY_NS   = 2000;
  localparam int IDLE_STANDBY_CYC  = (IDLE_STANDBY_NS * CLK_MHZ + 999) / 1000;
  localparam int CLKRUN_HOLD_NS    = 100;
  localparam int CLKRUN_HOLD_CYC   = (CLKRUN_HOLD_NS * CLK_MHZ + 999) / 1000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic       stateWrite;
    logic [1:0] stateValue;
    logic       baseInit;
    logic       wakeEnable;
    logic       clkRunEnable;
    logic       deepEnable;
  } pscr_cfg_t;

  typedef struct packed {
    logic linkValid;
    logic wakePacket;
    logic busyNeed;
  } pscr_evt_t;

endpackage : pscr_pkg

//--- rtl/pscr_clkrun.sv
// Clock-run open-drain driver for the device end.
// Assumes host drives the shared line; wire level resolved outside.
`timescale 1ns/1ps
module pscr_clkrun #(
  parameter int HOLD_CYC = pscr_pkg::CLKRUN_HOLD_CYC
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic needClk,
  input  wire logic enable,
  input  wire logic clkRunIn_n,
  output logic      clkRunOut_n,
  output logic      clkRunOe_n
);
  logic [7:0] holdCnt_reg;
  logic       claim;

  // Disabled mode claims the clock always, idle or not
  assign claim = needClk || !enable || (holdCnt_reg != 8'h00);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      holdCnt_reg <= 8'h00;
    end else if (needClk) begin
      holdCnt_reg <= 8'(HOLD_CYC);
    end else if (holdCnt_reg != 8'h00) begin
      holdCnt_reg <= holdCnt_reg - 8'h01;
    end
  end

  // Start pulling only once the host has released; then hold until the claim ends,
  // because our own pull makes the line read low and would otherwise toggle it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkRunOut_n <= 1'b0;
      clkRunOe_n  <= 1'b1;
    end else begin
      clkRunOut_n <= 1'b0;
      clkRunOe_n  <= !(claim && (clkRunIn_n || !clkRunOe_n));
    end
  end
endmodule : pscr_clkrun

//--- rtl/pscr_linkmon.sv
// Link status change detector.
// Assumes linkValid is a synchronous level.
`timescale 1ns/1ps
module pscr_linkmon (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic linkValid,
  output logic      linkUp,
  output logic      linkDrop
);
  logic last_reg;
  logic seen_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_reg <= 1'b0;
      seen_reg <= 1'b0;
      linkUp   <= 1'b0;
      linkDrop <= 1'b0;
    end else begin
      last_reg <= linkValid;
      seen_reg <= 1'b1;
      // First sample after reset is a baseline, not a change
      linkUp   <= seen_reg && linkValid && !last_reg;
      linkDrop <= seen_reg && !linkValid && last_reg;
    end
  end
endmodule : pscr_linkmon

//--- test/pscr_power_seq_checker.sv
// Port assertions for the power-state sequencer.
// Bound to pscr_power_seq; single clock domain, async low reset.
`timescale 1ns/1ps
module pscr_power_seq_checker #(
  parameter int IDLE_CYC = 4
) (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire pscr_pkg::pscr_cfg_t   cfg,
  input wire pscr_pkg::pscr_evt_t   evt,
  input wire logic                  clkRunIn_n,
  input wire logic                  clkRunOut_n,
  input wire logic                  clkRunOe_n,
  input wire logic                  pmeOut_n,
  input wire logic                  pmeOe_n,
  input wire logic                  pmeStatus,
  input wire pscr_pkg::pscr_state_t powerState,
  input wire logic                  busMasterAllow,
  input wire logic                  irqAllow,
  input wire logic                  deepPowerDown,
  input wire logic                  standby
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_drive_low_only: assert property (!clkRunOut_n && !pmeOut_n)
    else $error("open-drain data level not low");
  a_claim_on_need: assert property (evt.busyNeed && clkRunIn_n |=> !clkRunOe_n)
    else $error("busy device did not pull clock-run");
  a_claim_held: assert property (evt.busyNeed && !clkRunOe_n |=> !clkRunOe_n)
    else $error("clock-run pull dropped while device busy");
  a_claim_disabled: assert property (!cfg.clkRunEnable && clkRunIn_n |=> !clkRunOe_n)
    else $error("clock not claimed with clock-run disabled");
  a_pme_from_status: assert property (pmeStatus |-> !pmeOe_n)
    else $error("wake status set but wake pin idle");
  a_master_in_d0: assert property (busMasterAllow |=> powerState == pscr_pkg::PSCR_D0A)
    else $error("bus mastering allowed outside active state");
  a_irq_in_d0: assert property (irqAllow |=> powerState inside {pscr_pkg::PSCR_D0U, pscr_pkg::PSCR_D0A})
    else $error("interrupts allowed in low power state");
  a_standby_idle: assert property (standby |-> $past(!evt.busyNeed, 2))
    else $error("standby while device busy");
  a_deep_enabled: assert property (deepPowerDown |-> $past(cfg.deepEnable))
    else $error("deep mode without enable bit");
  a_wake_enabled: assert property ($rose(pmeStatus) |-> $past(cfg.wakeEnable) || $past(cfg.wakeEnable, 2))
    else $error("wake event with wake disabled");
  a_link_wake: assert property ($changed(evt.linkValid) && cfg.wakeEnable && powerState == pscr_pkg::PSCR_D0A
    |-> ##[1:3] pmeStatus)
    else $error("link change did not wake");
endmodule : pscr_power_seq_checker

bind pscr_power_seq pscr_power_seq_checker #(.IDLE_CYC(IDLE_CYC)) pscr_power_seq_checker_i (
  .clk(clk), .nrst(nrst), .cfg(cfg), .evt(evt), .clkRunIn_n(clkRunIn_n), .clkRunOut_n(clkRunOut_n),
  .clkRunOe_n(clkRunOe_n), .pmeOut_n(pmeOut_n), .pmeOe_n(pmeOe_n), .pmeStatus(pmeStatus),
  .powerState(powerState), .busMasterAllow(busMasterAllow), .irqAllow(irqAllow),
  .deepPowerDown(deepPowerDown), .standby(standby));

//--- test/pscr_host_model.sv
// Behavioural host clock controller on the shared clock-run line.
// Assumes the device pulls the line through its enable only.
`timescale 1ns/1ps
module pscr_host_model #(
  parameter int RESTORE_CYC = 3
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic stopReq,
  input  wire logic devOe_n,
  output logic      lineLvl_n
);
  logic       hostOe_n_reg;
  logic [4:0] waitCnt_reg;
  // ****************************************
  // Wire and host side
  // ****************************************
  // Pull-up: high only while nobody pulls
  assign lineLvl_n = hostOe_n_reg & devOe_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hostOe_n_reg <= 1'h0;
      waitCnt_reg  <= 5'h0;
    end else if (!hostOe_n_reg) begin
      hostOe_n_reg <= stopReq;
      waitCnt_reg  <= 5'h0;
    end else if (!stopReq || waitCnt_reg == 5'(RESTORE_CYC)) begin
      // Well inside the half microsecond limit
      hostOe_n_reg <= 1'h0;
    end else if (!devOe_n) begin
      waitCnt_reg <= waitCnt_reg + 5'h1;
    end
  end
endmodule : pscr_host_model

//--- test/testbench.sv
// Directed bench for the power-state sequencer and clock-run host.
// Assumes the host model drives the resolved clock-run level.
`timescale 1ns/1ps
module testbench;
  logic                  clk, nrst, pmeClear, stopReq, clkRunIn_n, clkRunOut_n, clkRunOe_n;
  logic                  pmeOut_n, pmeOe_n, pmeStatus, busMasterAllow, targetAllow, irqAllow;
  logic                  linkKeep, deepPowerDown, standby;
  pscr_pkg::pscr_cfg_t   cfg;
  pscr_pkg::pscr_evt_t   evt;
  pscr_pkg::pscr_state_t powerState;
  int                    miscompares = 0;
  int                    checks = 0;
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  pscr_power_seq #(.IDLE_CYC(4)) pscr_power_seq_i (.clk(clk), .nrst(nrst), .cfg(cfg), .evt(evt),
    .pmeClear(pmeClear), .clkRunIn_n(clkRunIn_n), .clkRunOut_n(clkRunOut_n), .clkRunOe_n(clkRunOe_n),
    .pmeOut_n(pmeOut_n), .pmeOe_n(pmeOe_n), .pmeStatus(pmeStatus), .powerState(powerState),
    .busMasterAllow(busMasterAllow), .targetAllow(targetAllow), .irqAllow(irqAllow),
    .linkKeep(linkKeep), .deepPowerDown(deepPowerDown), .standby(standby));
  pscr_host_model pscr_host_model_i (.clk(clk), .nrst(nrst), .stopReq(stopReq), .devOe_n(clkRunOe_n),
    .lineLvl_n(clkRunIn_n));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  function automatic logic pick(input int sel);
    case (sel)
      0: return pmeStatus;
      1: return clkRunOe_n;
      default: return standby;
    endcase
  endfunction : pick
  // Bounded wait; a miss ends the run
  task automatic waitSig(input int sel, input logic exp);
    for (int n = 0; n < 40 && pick(sel) !== exp; n++) tick(1);
    chk("wait", 8'(pick(sel)), 8'(exp));
    if (pick(sel) !== exp) end_sim();
  endtask : waitSig
  task automatic writeState(input logic [1:0] v);
    @(posedge clk);
    cfg.stateWrite <= 1'h1;
    cfg.stateValue <= v;
    @(posedge clk);
    cfg.stateWrite <= 1'h0;
    tick(3);
  endtask : writeState
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: cfg.baseInit <= 1'h1;
      1: pmeClear <= 1'h1;
      default: evt.wakePacket <= 1'h1;
    endcase
    @(posedge clk);
    cfg.baseInit <= 1'h0;
    pmeClear <= 1'h0;
    evt.wakePacket <= 1'h0;
    tick(2);
  endtask : pulse
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    nrst = 1'h0;
    pmeClear = 1'h0;
    stopReq = 1'h0;
    cfg = '0;
    cfg.clkRunEnable = 1'h1;
    evt = '0;
    evt.linkValid = 1'h1;
    tick(4);
    chk("state", 8'(powerState), 8'(pscr_pkg::PSCR_D0U));
    chk("target", 8'(targetAllow), 8'h01);
    chk("pme", 8'(pmeOe_n), 8'h01);
    @(posedge clk) nrst <= 1'h1;
    writeState(pscr_pkg::PSCR_PS_D0);
    chk("state", 8'(powerState), 8'(pscr_pkg::PSCR_D0U));
    pulse(0);
    chk("state", 8'(powerState), 8'(pscr_pkg::PSCR_D0A));
    chk("master", 8'(busMasterAllow), 8'h01);
    waitSig(2, 1'h1);
    @(posedge clk) evt.busyNeed <= 1'h1;
    tick(3);
    chk("standby", 8'(standby), 8'h00);
    @(posedge clk) stopReq <= 1'h1;
    waitSig(1, 1'h0);
    @(posedge clk) evt.busyNeed <= 1'h0;
    tick(14);
    chk("pull", 8'(clkRunOe_n), 8'h01);
    chk("line", 8'(clkRunIn_n), 8'h01);
    @(posedge clk) cfg.clkRunEnable <= 1'h0;
    waitSig(1, 1'h0);
    @(posedge clk) stopReq <= 1'h0;
    @(posedge clk) evt.linkValid <= 1'h0;
    tick(4);
    chk("status", 8'(pmeStatus), 8'h00);
    @(posedge clk) cfg.wakeEnable <= 1'h1;
    @(posedge clk) evt.linkValid <= 1'h1;
    waitSig(0, 1'h1);
    chk("pme", 8'(pmeOe_n), 8'h00);
    pulse(1);
    for (int v = 1; v < 4; v++) begin
      writeState(2'(v));
      chk("state", 8'(powerState), 8'(v + 1));
      chk("master", 8'(busMasterAllow), 8'h00);
      chk("irq", 8'(irqAllow), 8'h00);
      chk("target", 8'(targetAllow), 8'h00);
      chk("link", 8'(linkKeep), 8'h01);
      pulse(2);
      chk("status", 8'(pmeStatus), 8'h01);
      pulse(1);
      chk("status", 8'(pmeStatus), 8'h00);
    end
    @(posedge clk) evt.linkValid <= 1'h0;
    waitSig(0, 1'h1);
    pulse(1);
    @(posedge clk) cfg.deepEnable <= 1'h1;
    tick(3);
    chk("deep", 8'(deepPowerDown), 8'h01);
    @(posedge clk) cfg.deepEnable <= 1'h0;
    tick(3);
    chk("deep", 8'(deepPowerDown), 8'h00);
    pulse(2);
    chk("status", 8'(pmeStatus), 8'h00);
    @(posedge clk) evt.linkValid <= 1'h1;
    waitSig(0, 1'h1);
    pulse(1);
    @(posedge clk) cfg.wakeEnable <= 1'h0;
    tick(3);
    chk("link", 8'(linkKeep), 8'h00);
    @(posedge clk) nrst <= 1'h0;
    tick(1);
    chk("state", 8'(powerState), 8'(pscr_pkg::PSCR_D0U));
    chk("target", 8'(targetAllow), 8'h01);
    @(posedge clk) cfg.wakeEnable <= 1'h1;
    @(posedge clk) nrst <= 1'h1;
    tick(4);
    chk("status", 8'(pmeStatus), 8'h00);
    chk("state", 8'(powerState), 8'(pscr_pkg::PSCR_D0U));
    end_sim();
  end
endmodule : testbench
